/* interval_capture_timer_pkg.sv */
// Constants for the interval / capture timer: register map, fields, reset values.
// Assumes an Avalon-MM slave with 32-bit data, one register per aligned word.
// Contract
// - Mode bit 0 selects interval mode, 1 selects capture mode with overflow.
// - Writing 1 to the clear bit clears the counter; bit self-clears; 0 does nothing.
// - Clock select 0000 stops; 0101 external rising; 0110 external falling; others unavailable.
// - Codes 1000 to 1111 select system clock divided by 1,2,4,8,16,64,256,1024.
// - Counter compares against a buffer that copies the compare data register.
// - Buffer reloads on counter clear start and on each match or overflow.
// - Interval mode: counter equal to compare value gives match and toggles output.
// - Match raises the match interrupt and clears the counter to zero.
// - Capture mode: capture pin event copies count into compare data, clears counter.
// - Capture mode: counter wrap past maximum raises the overflow interrupt.
// - Match interrupt reaches the processor only while its enable bit is 1.
// - Match flag clears itself when the processor vectors to its service routine.
// - Overflow interrupt reaches the processor only while its enable bit is 1.
// - Overflow flag clears itself when the processor vectors to its service routine.
// - Capture edge field: 00 off, 01 falling, 10 rising, 11 both edges.
package interval_capture_timer_pkg;
  // Byte addresses (printed offsets are not word aligned: index times four)
  localparam logic [7:0] IDX_CTRL = 8'h00_D0;
  localparam logic [7:0] IDX_DATA = 8'h00_D1;
  localparam logic [7:0] IDX_COUNT = 8'h00_D2;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h00_D8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h00_D9;
  localparam logic [7:0] IDX_CAPTURE_CFG = 8'h00_DA;
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_DATA = {IDX_DATA, 2'b00};
  localparam logic [9:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_CAPTURE_CFG = {IDX_CAPTURE_CFG, 2'b00};
  // Control register fields
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_CLEAR_BIT = 4;
  localparam int CTRL_CS_LSB = 0;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // Interrupt status / mask bits
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Clock select codes
  localparam logic [3:0] CS_STOP = 4'h0;
  localparam logic [3:0] CS_EXT_RISE = 4'h5;
  localparam logic [3:0] CS_EXT_FALL = 4'h6;
  // Capture edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int PRESCALE_WIDTH = 10;
endpackage

/* interval_capture_timer.sv */
// Interval / capture timer with Avalon-MM register access, a match and an overflow interrupt line, and one combined line.
// Assumes pins arrive asynchronously; vectoring acknowledges come from the same clock.
`timescale 1ns/10ps
module interval_capture_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Pins
  input wire logic i_external_count_clock_pin,
  input wire logic i_capture_trigger_pin,
  output logic o_match_toggle_output,
  // Processor vector acknowledges and interrupts
  input wire logic i_match_vector_ack,
  input wire logic i_overflow_vector_ack,
  output logic o_match_irq,
  output logic o_overflow_irq,
  output logic o_irq
);

  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] data;
    logic [7:0] buffer;
    logic [7:0] count;
    logic [9:0] prescale;
    logic [2:0] ext_sync;
    logic ext_level;
    logic [2:0] cap_sync;
    logic cap_level;
    logic [1:0] edge_sel;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic match_flag;
    logic ovf_flag;
    logic toggle;
    logic match_irq;
    logic ovf_irq;
    logic irq;
    logic [31:0] rdata;
    logic wait_n;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // Tick from the prescaler for divide code 1000..1111; the last stage carries
  function automatic logic div_tick(input logic [2:0] sel, input logic [9:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      3'd0: t = 1'b1;
      3'd1: t = (pre[0:0] == 1'h1);
      3'd2: t = (pre[1:0] == 2'h3);
      3'd3: t = (pre[2:0] == 3'h7);
      3'd4: t = (pre[3:0] == 4'hF);
      3'd5: t = (pre[5:0] == 6'h3F);
      3'd6: t = (pre[7:0] == 8'hFF);
      default: t = (pre == 10'h3FF);
    endcase
    return t;
  endfunction

  // Byte lane 0 write helper
  function automatic logic lane0_write(input logic [9:0] addr, input logic [9:0] target,
                                       input logic wr, input logic [3:0] be);
    return wr && be[0] && (addr == target);
  endfunction

  always_comb begin
    logic [3:0] cs;
    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;
    logic cap_event;
    logic tick;
    logic cap_mode;
    logic clear_req;
    logic match;
    logic ovf;
    logic bus_op;
    logic [1:0] raised;
    cs = 4'h0;
    ext_rise = 1'b0;
    ext_fall = 1'b0;
    cap_rise = 1'b0;
    cap_fall = 1'b0;
    cap_event = 1'b0;
    tick = 1'b0;
    cap_mode = 1'b0;
    clear_req = 1'b0;
    match = 1'b0;
    ovf = 1'b0;
    bus_op = 1'b0;
    raised = 2'h0;
    st_next = st_reg;

    // Three-stage synchronisers; only stages two and three are compared
    st_next.ext_sync = {st_reg.ext_sync[1:0], i_external_count_clock_pin};
    st_next.cap_sync = {st_reg.cap_sync[1:0], i_capture_trigger_pin};
    if (st_reg.ext_sync[1] == st_reg.ext_sync[2]) begin
      st_next.ext_level = st_reg.ext_sync[2];
    end
    if (st_reg.cap_sync[1] == st_reg.cap_sync[2]) begin
      st_next.cap_level = st_reg.cap_sync[2];
    end
    ext_rise = (st_next.ext_level && !st_reg.ext_level);
    ext_fall = (!st_next.ext_level && st_reg.ext_level);
    cap_rise = (st_next.cap_level && !st_reg.cap_level);
    cap_fall = (!st_next.cap_level && st_reg.cap_level);

    // Capture edge choice
    case (st_reg.edge_sel)
      interval_capture_timer_pkg::EDGE_FALL: cap_event = cap_fall;
      interval_capture_timer_pkg::EDGE_RISE: cap_event = cap_rise;
      interval_capture_timer_pkg::EDGE_BOTH: cap_event = cap_rise || cap_fall;
      default: cap_event = 1'b0;
    endcase

    // Free-running prescaler shared by all divide codes
    st_next.prescale = st_reg.prescale + 10'h001;
    cs = st_reg.ctrl[interval_capture_timer_pkg::CTRL_CS_LSB +: 4];
    cap_mode = st_reg.ctrl[interval_capture_timer_pkg::CTRL_MODE_BIT];
    clear_req = st_reg.ctrl[interval_capture_timer_pkg::CTRL_CLEAR_BIT];

    // Count clock select; unavailable codes behave as stopped
    if (cs[3]) begin
      tick = div_tick(cs[2:0], st_reg.prescale);
    end else if (cs == interval_capture_timer_pkg::CS_EXT_RISE) begin
      tick = ext_rise;
    end else if (cs == interval_capture_timer_pkg::CS_EXT_FALL) begin
      tick = ext_fall;
    end else begin
      tick = 1'b0;
    end

    // Counter: clear request first, then match, capture, counting
    if (clear_req) begin
      st_next.count = 8'h00;
      st_next.buffer = st_reg.data;
      st_next.ctrl[interval_capture_timer_pkg::CTRL_CLEAR_BIT] = 1'b0;
    end else if (!cap_mode && st_reg.count == st_reg.buffer && tick) begin
      // Comparison against the buffer, never the live data register
      match = 1'b1;
      st_next.count = 8'h00;
      st_next.toggle = !st_reg.toggle;
      st_next.buffer = st_reg.data;
    end else if (cap_mode && cap_event) begin
      st_next.data = st_reg.count;
      st_next.count = 8'h00;
    end else if (tick) begin
      st_next.count = st_reg.count + 8'h01;
      if (cap_mode && st_reg.count == 8'hFF) begin
        ovf = 1'b1;
        st_next.buffer = st_reg.data;
      end
    end

    // Request flags: a new event wins over a vector acknowledge
    if (match) begin
      st_next.match_flag = 1'b1;
    end else if (i_match_vector_ack) begin
      st_next.match_flag = 1'b0;
    end
    if (ovf) begin
      st_next.ovf_flag = 1'b1;
    end else if (i_overflow_vector_ack) begin
      st_next.ovf_flag = 1'b0;
    end

    // Bus slave: one wait cycle, then answer with waitrequest low
    bus_op = (i_read || i_write) && !st_reg.wait_n;
    st_next.wait_n = bus_op;
    st_next.rdata = 32'h0000_0000;
    raised = {ovf, match};
    if (bus_op && i_write) begin
      if (lane0_write(i_address, interval_capture_timer_pkg::ADDR_CTRL, i_write, i_byteenable)) begin
        // Writing 0 to the clear bit leaves a pending clear alone
        st_next.ctrl = {i_writedata[5], i_writedata[4] | st_next.ctrl[4], i_writedata[3:0]};
      end else if (lane0_write(i_address, interval_capture_timer_pkg::ADDR_DATA, i_write, i_byteenable)) begin
        // Hardware capture in the same cycle takes precedence
        if (!(cap_mode && cap_event && !clear_req)) begin
          st_next.data = i_writedata[7:0];
        end
      end else if (lane0_write(i_address, interval_capture_timer_pkg::ADDR_IRQ_MASK, i_write, i_byteenable)) begin
        st_next.irq_mask = i_writedata[1:0];
      end else if (lane0_write(i_address, interval_capture_timer_pkg::ADDR_CAPTURE_CFG, i_write, i_byteenable)) begin
        st_next.edge_sel = i_writedata[1:0];
      end
    end else if (bus_op && i_read) begin
      if (i_address == interval_capture_timer_pkg::ADDR_CTRL) begin
        st_next.rdata = {26'h000_0000, st_reg.ctrl};
      end else if (i_address == interval_capture_timer_pkg::ADDR_DATA) begin
        st_next.rdata = {24'h00_0000, st_reg.data};
      end else if (i_address == interval_capture_timer_pkg::ADDR_COUNT) begin
        st_next.rdata = {24'h00_0000, st_reg.count};
      end else if (i_address == interval_capture_timer_pkg::ADDR_IRQ_STATUS) begin
        st_next.rdata = {30'h0000_0000, st_reg.irq_status};
      end else if (i_address == interval_capture_timer_pkg::ADDR_IRQ_MASK) begin
        st_next.rdata = {30'h0000_0000, st_reg.irq_mask};
      end else if (i_address == interval_capture_timer_pkg::ADDR_CAPTURE_CFG) begin
        st_next.rdata = {30'h0000_0000, st_reg.edge_sel};
      end else begin
        st_next.rdata = 32'h0000_0000; // Unmapped reads return zero
      end
    end

    // Sticky status: read clears, new events in the same cycle stay set
    if (bus_op && i_read && i_address == interval_capture_timer_pkg::ADDR_IRQ_STATUS) begin
      st_next.irq_status = raised;
    end else begin
      st_next.irq_status = st_reg.irq_status | raised;
    end

    // Interrupt outputs, gated by the mask / enable bits
    st_next.match_irq = st_next.match_flag && st_next.irq_mask[interval_capture_timer_pkg::IRQ_MATCH_BIT];
    st_next.ovf_irq = st_next.ovf_flag && st_next.irq_mask[interval_capture_timer_pkg::IRQ_OVF_BIT];
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  // Single state register; reset loads constants only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= interval_capture_timer_pkg::CTRL_RESET;
      st_reg.data <= interval_capture_timer_pkg::DATA_RESET;
      st_reg.irq_status <= interval_capture_timer_pkg::IRQ_RESET;
      st_reg.irq_mask <= interval_capture_timer_pkg::IRQ_RESET;
      st_reg.edge_sel <= interval_capture_timer_pkg::EDGE_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_readdata = st_reg.rdata;
  assign o_waitrequest = !st_reg.wait_n;
  assign o_match_toggle_output = st_reg.toggle;
  assign o_match_irq = st_reg.match_irq;
  assign o_overflow_irq = st_reg.ovf_irq;
  assign o_irq = st_reg.irq;

endmodule

/* timer_pin_model.sv */
// Far-side pin model: external count clock and capture trigger pins.
// Assumes the bench asks for one pulse at a time; pins rest low between pulses.
`timescale 1ns/10ps
module timer_pin_model (
  // Clock and pulse requests
  input wire logic i_clk,
  input wire logic i_ext_req,
  input wire logic i_cap_req,
  // Pins
  output logic o_ext_clk,
  output logic o_cap_pin
);
  logic [3:0] ext_cnt = 4'h0;
  logic [3:0] cap_cnt = 4'h0;
  // Each pulse is high five cycles, then low until the next request, so the 3-flop sync sees both edges
  always @(posedge i_clk) begin
    if (i_ext_req) ext_cnt <= 4'hA;
    else if (ext_cnt != 4'h0) ext_cnt <= ext_cnt - 4'h1;
    if (i_cap_req) cap_cnt <= 4'hA;
    else if (cap_cnt != 4'h0) cap_cnt <= cap_cnt - 4'h1;
  end
  assign o_ext_clk = (ext_cnt > 4'h5);
  assign o_cap_pin = (cap_cnt > 4'h5);
endmodule

/* interval_capture_timer_asserts.sv */
// Port checker for the timer: bus answer timing, interrupt combine, acknowledges.
// Assumes the single clock and the active-low reset of the top module.
`timescale 1ns/10ps
module interval_capture_timer_asserts (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  // Acknowledges, pins and interrupts
  input wire logic i_match_vector_ack,
  input wire logic i_overflow_vector_ack,
  input wire logic o_match_toggle_output,
  input wire logic o_match_irq,
  input wire logic o_overflow_irq,
  input wire logic o_irq
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // The line follows the read-cleared status, so it only has to agree with a source when it rises
  AST_IRQ_OR: assert property ($rose(o_irq) |-> (o_match_irq || o_overflow_irq))
    else $error("combined interrupt rose with no enabled source");
  AST_WAIT_ANSWER: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered one cycle later");
  AST_WAIT_ONE: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer stood longer than one cycle");
  AST_WAIT_IDLE: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
    else $error("answer without a request");
  AST_READ_UPPER: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  AST_UNMAPPED_ZERO: assert property (i_read && !o_waitrequest && i_address == 10'h000 |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  // A fresh match may win over the acknowledge, shown by a toggle
  AST_MATCH_ACK: assert property (i_match_vector_ack |-> ##[1:2] (!o_match_irq || $changed(o_match_toggle_output)))
    else $error("match request stayed after acknowledge");
  AST_OVF_ACK: assert property (i_overflow_vector_ack |-> ##[1:2] !o_overflow_irq)
    else $error("overflow request stayed after acknowledge");
endmodule
bind interval_capture_timer interval_capture_timer_asserts interval_capture_timer_asserts_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_match_vector_ack(i_match_vector_ack),
  .i_overflow_vector_ack(i_overflow_vector_ack), .o_match_toggle_output(o_match_toggle_output),
  .o_match_irq(o_match_irq), .o_overflow_irq(o_overflow_irq), .o_irq(o_irq));

/* interval_capture_timer_tb.sv */
// Self-checking bench: Avalon tasks, pin model, one task per scenario.
// Assumes every bus answer comes within 50 cycles of the request.
`timescale 1ns/10ps
module interval_capture_timer_tb;
  localparam logic [9:0] AC = interval_capture_timer_pkg::ADDR_CTRL;
  localparam logic [9:0] AD = interval_capture_timer_pkg::ADDR_DATA;
  localparam logic [9:0] AN = interval_capture_timer_pkg::ADDR_COUNT;
  localparam logic [9:0] AS = interval_capture_timer_pkg::ADDR_IRQ_STATUS;
  localparam logic [9:0] AM = interval_capture_timer_pkg::ADDR_IRQ_MASK;
  localparam logic [9:0] AE = interval_capture_timer_pkg::ADDR_CAPTURE_CFG;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, m_ack = 1'b0, v_ack = 1'b0;
  logic ext_req = 1'b0, cap_req = 1'b0, wait_req, ext_pin, cap_pin, tog, m_irq, v_irq, irq;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  int n_mismatch = 0, checks = 0, g;
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  // Byte lanes stay all on: every register sits in lane 0
  interval_capture_timer interval_capture_timer_inst (.i_clk(clk), .i_rst_n(rst_n), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hF), .o_readdata(rdata),
    .o_waitrequest(wait_req), .i_external_count_clock_pin(ext_pin), .i_capture_trigger_pin(cap_pin),
    .o_match_toggle_output(tog), .i_match_vector_ack(m_ack), .i_overflow_vector_ack(v_ack),
    .o_match_irq(m_irq), .o_overflow_irq(v_irq), .o_irq(irq));
  timer_pin_model timer_pin_model_inst (.i_clk(clk), .i_ext_req(ext_req), .i_cap_req(cap_req),
    .o_ext_clk(ext_pin), .o_cap_pin(cap_pin));
  task final_report;
    $display("Totals: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task timeout(input string nm);
    n_mismatch++;
    $display("[ERR] %s expected done seen timeout", nm);
    final_report();
  endtask
  // Request held until the edge that samples waitrequest low; reads compared there
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) timeout("waitrequest");
    if (!w) chk("readdata", rdata, e);
  endtask
  task pulse(input logic cap, input int k);
    repeat (k) begin
      @(posedge clk);
      if (cap) cap_req <= 1'b1;
      else ext_req <= 1'b1;
      @(posedge clk);
      cap_req <= 1'b0;
      ext_req <= 1'b0;
      repeat (16) @(posedge clk);
    end
  endtask
  // Skip to one toggle, then count cycles to the next
  task gap(input int e);
    logic t;
    repeat (2) begin
      t = tog;
      g = 0;
      while (tog === t && g < 3000) begin
        @(posedge clk);
        g++;
      end
    end
    if (g >= 3000) timeout("toggle");
    chk("toggle gap", g, e);
  endtask
  task t_regs;
    bus(0, AC, 32'h0, 32'h0);
    bus(0, AM, 32'h0, 32'h0);
    bus(0, 10'h000, 32'h0, 32'h0);
    bus(1, AC, 32'h27, 32'h0);
    bus(0, AC, 32'h0, 32'h27);
    bus(1, AC, 32'h0, 32'h0);
    $display("test regs done");
  endtask
  task t_ext;
    bus(1, AD, 32'hFF, 32'h0);
    bus(1, AC, 32'h15, 32'h0);
    pulse(0, 3);
    bus(0, AN, 32'h0, 32'h3);
    bus(1, AC, 32'h06, 32'h0);
    pulse(0, 2);
    bus(0, AN, 32'h0, 32'h5);
    bus(1, AC, 32'h10, 32'h0);
    bus(0, AN, 32'h0, 32'h0);
    bus(0, AC, 32'h0, 32'h0);
    bus(1, AC, 32'h01, 32'h0);
    pulse(0, 1);
    bus(0, AN, 32'h0, 32'h0);
    $display("test external clock done");
  endtask
  task t_div;
    int divs[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
    bus(1, AD, 32'h0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1, AC, 32'h18 + 32'(i), 32'h0);
      gap(divs[i]);
    end
    bus(1, AD, 32'h3, 32'h0);
    bus(1, AC, 32'h18, 32'h0);
    gap(4);
    bus(1, AD, 32'h1, 32'h0);
    gap(2);
    bus(1, AD, 32'h3, 32'h0);
    bus(1, AC, 32'h18, 32'h0);
    $display("test dividers done");
  endtask
  task t_irq;
    bus(1, AM, 32'h1, 32'h0);
    repeat (8) @(posedge clk);
    chk("irq", irq, 32'h1);
    bus(0, AS, 32'h0, 32'h1);
    bus(1, AM, 32'h0, 32'h0);
    repeat (8) @(posedge clk);
    chk("irq masked", irq, 32'h0);
    bus(1, AM, 32'h1, 32'h0);
    bus(1, AC, 32'h0, 32'h0);
    chk("match irq", m_irq, 32'h1);
    m_ack <= 1'b1;
    @(posedge clk);
    m_ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk("match irq acked", m_irq, 32'h0);
    bus(1, AM, 32'h0, 32'h0);
    $display("test match irq done");
  endtask
  task t_cap;
    bus(1, AE, 32'h2, 32'h0);
    bus(1, AC, 32'h35, 32'h0);
    pulse(0, 4);
    pulse(1, 1);
    bus(0, AD, 32'h0, 32'h4);
    bus(0, AN, 32'h0, 32'h0);
    bus(1, AE, 32'h0, 32'h0);
    pulse(0, 2);
    pulse(1, 1);
    bus(0, AN, 32'h0, 32'h2);
    bus(1, AE, 32'h1, 32'h0);
    pulse(1, 1);
    bus(0, AD, 32'h0, 32'h2);
    bus(1, AE, 32'h3, 32'h0);
    pulse(0, 1);
    pulse(1, 1);
    bus(0, AD, 32'h0, 32'h0);
    bus(1, AM, 32'h2, 32'h0);
    bus(1, AC, 32'h38, 32'h0);
    g = 0;
    while (irq !== 1'b1 && g < 400) begin
      @(posedge clk);
      g++;
    end
    if (g >= 400) timeout("overflow");
    chk("overflow irq", v_irq, 32'h1);
    bus(1, AC, 32'h20, 32'h0);
    v_ack <= 1'b1;
    @(posedge clk);
    v_ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk("overflow irq acked", v_irq, 32'h0);
    // Status is sticky: the acknowledge leaves it, earlier matches still show in bit 0
    bus(0, AS, 32'h0, 32'h3);
    bus(0, AS, 32'h0, 32'h0);
    $display("test capture done");
  endtask
  // Main sequence: reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_ext();
    t_div();
    t_irq();
    t_cap();
    final_report();
  end
endmodule
